// ---- logic/scale_avg_pkg.sv ----
/*
 * shared constants and types for the measurement scaling and averaging block.
 * assumes one clock domain and integer ratios; power coefficient is q8.8.
 */
package scale_avg_pkg;
  localparam int DW      = 24;
  localparam int NCH     = 7;
  localparam int PTR_W   = 8;
  localparam int WIN_MAX = 256;
  localparam int COEF_FRAC = 8;
  localparam int MIN_LEVEL_DIV = 100;

  typedef logic signed [DW-1:0] sample_t;
  typedef sample_t [NCH-1:0]    ch_vec_t;

  localparam int CH_V   = 0;
  localparam int CH_I   = 1;
  localparam int CH_P   = 2;
  localparam int CH_UPK = 5;
  // channel order: v, i, p, s, q, upk, ipk
  localparam logic [NCH-1:0] DIV_MASK = 7'h5e;
  localparam logic [NCH-1:0] VT_MASK  = 7'h21;
  localparam logic [NCH-1:0] CT_MASK  = 7'h42;
  localparam logic [NCH-1:0] PWR_MASK = 7'h1c;

  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_AVG    = 8'h04;
  localparam logic [7:0] OFS_SENSOR = 8'h08;
  localparam logic [7:0] OFS_VT     = 8'h0c;
  localparam logic [7:0] OFS_CT     = 8'h10;
  localparam logic [7:0] OFS_COEF   = 8'h14;
  localparam logic [7:0] OFS_PEAK   = 8'h18;
  localparam logic [7:0] OFS_RANGE  = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  localparam int MODE_SENSOR_BIT = 0;
  localparam int MODE_XFMR_BIT   = 1;
  localparam int MODE_LINE_BIT   = 2;
  localparam int MODE_CUT_LSB    = 4;
  localparam int MODE_FREQ_BIT   = 8;
  localparam int MODE_RATE_LSB   = 12;
  localparam int AVG_EN_BIT      = 0;
  localparam int AVG_TYPE_BIT    = 1;
  localparam int AVG_K_LSB       = 4;
  localparam int AVG_M_LSB       = 8;
  localparam int RANGE_I_LSB     = 16;

  localparam logic [15:0] RST_RATIO = 16'h0001;
  localparam logic [15:0] RST_COEF  = 16'h0100;
  localparam logic [15:0] RST_RANGE = 16'h0064;
  localparam logic [2:0]  PEAK_LOW  = 3'h3;
  localparam logic [2:0]  PEAK_HIGH = 3'h6;
  localparam logic [2:0]  K_MIN     = 3'h1;
  localparam logic [2:0]  K_MAX     = 3'h6;
  localparam logic [3:0]  M_MIN     = 4'h3;
  localparam logic [3:0]  M_MAX     = 4'h8;

  typedef enum logic [3:0] {
    RATE_50MS = 4'h0, RATE_100MS = 4'h1, RATE_250MS = 4'h2, RATE_500MS = 4'h3, RATE_1S = 4'h4,
    RATE_2S = 4'h5, RATE_5S = 4'h6, RATE_10S = 4'h7, RATE_20S = 4'h8
  } update_rate_t;

  typedef enum logic {BUS_IDLE = 1'b0, BUS_DATA = 1'b1} bus_state_t;

  function automatic sample_t sat(input logic signed [79:0] v);
    if (v > 80'sd8388607) return 24'sh7fffff;
    if (v < -80'sd8388608) return 24'sh800000;
    return v[DW-1:0];
  endfunction
endpackage

// ---- logic/avg_if.sv ----
/*
 * carrier between the block's control and its averaging core.
 * assumes the core answers combinationally in the cycle in_valid is high.
 */
`timescale 1ns/10ps
interface avg_if;
  import scale_avg_pkg::*;
  logic       in_valid;
  ch_vec_t    in_data;
  logic       restart;
  logic       enable;
  logic       avg_type;
  logic [2:0] k_log2;
  logic [3:0] m_log2;
  ch_vec_t    out_data;
  logic       primed;
  modport ctrl (output in_valid, in_data, restart, enable, avg_type, k_log2, m_log2, input out_data, primed);
  modport core (input in_valid, in_data, restart, enable, avg_type, k_log2, m_log2, output out_data, primed);
endinterface

// ---- logic/pair_buffer.sv ----
/*
 * two-entry valid/ready buffer; the head entry drives the output directly.
 * assumes the reader may hold out_ready low for any length of time.
 */
`timescale 1ns/10ps
module pair_buffer #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  logic [W-1:0] tail;
  logic         tail_valid;
  logic         push;
  logic         pop;

  assign in_ready_out = !tail_valid;
  assign push = in_valid_in && !tail_valid;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      tail_valid    <= 1'b0;
    end else if (pop) begin
      out_valid_out <= tail_valid || push;
      tail_valid    <= 1'b0;
    end else if (push) begin
      out_valid_out <= 1'b1;
      tail_valid    <= out_valid_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_data_out <= '0;
      tail         <= '0;
    end else if (pop) begin
      out_data_out <= tail_valid ? tail : in_data_in;
    end else if (push) begin
      if (out_valid_out) begin
        tail <= in_data_in;
      end else begin
        out_data_out <= in_data_in;
      end
    end
  end
endmodule

// ---- logic/avg_core.sv ----
/*
 * per-channel exponential and moving averager.
 * assumes in_valid pulses once per update and the caller takes out_data then.
 */
`timescale 1ns/10ps
module avg_core (
  input wire logic clk_in,
  input wire logic rst_in,
  avg_if.core      av
);
  import scale_avg_pkg::*;
  logic             primed;
  logic             first;
  logic [PTR_W-1:0] ptr;

  assign first = !primed || av.restart;
  assign av.primed = primed;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      primed <= 1'b0;
    end else if (av.in_valid) begin
      primed <= 1'b1;
    end else if (av.restart) begin
      primed <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ptr <= '0;
    end else if (av.in_valid) begin
      ptr <= ptr + 8'h01;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    sample_t                     ema;
    logic signed [DW+PTR_W-1:0]  sum;
    sample_t                     win [WIN_MAX];
    sample_t                     m;
    sample_t                     old;
    sample_t                     e_next;
    logic signed [DW:0]          diff;
    logic signed [DW+PTR_W-1:0]  s_next;

    assign m    = av.in_data[c];
    assign diff = m - ema;
    // a window of 256 wraps to ptr itself, which is the oldest entry
    assign old  = win[ptr - (8'h01 << av.m_log2)];
    assign e_next = first ? m : sample_t'(ema + (diff >>> av.k_log2));
    // restart prefills the window, so the mean starts at the first sample
    assign s_next = first ? ((DW+PTR_W)'(m) <<< av.m_log2) : sum - old + m;
    assign av.out_data[c] = !av.enable ? m : av.avg_type ? sample_t'(s_next >>> av.m_log2) : e_next;

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        ema <= '0;
        sum <= '0;
      end else if (av.in_valid) begin
        ema <= e_next;
        sum <= s_next;
      end
    end

    always_ff @(posedge clk_in) begin
      if (av.in_valid) begin
        for (int i = 0; i < WIN_MAX; i++) begin
          if (first || ptr == PTR_W'(i)) begin
            win[i] <= m;
          end
        end
      end
    end
  end

  a_first_passes: assert property (@(posedge clk_in) disable iff (rst_in)
    av.in_valid && av.restart |-> av.out_data == av.in_data)
    else $error("first sample after restart not passed through");
  a_primed_after: assert property (@(posedge clk_in) disable iff (rst_in)
    av.in_valid |=> primed)
    else $error("averager not primed after an update");
endmodule

// ---- logic/scale_avg_top.sv ----
/*
 * scaling and averaging of per-element measured values, with an ahb-lite register slave.
 * assumes raw values come on the same clock, one strobe per data update.
 */
`timescale 1ns/10ps
// Functional notes
// - a writable sensor ratio holds millivolts per ampere of current.
// - sensor mode divides current, powers and current peak by the ratio.
// - transformer mode multiplies voltage and voltage peak by the voltage ratio.
// - transformer mode multiplies current and current peak by the current ratio.
// - transformer mode multiplies powers by voltage ratio, current ratio and coefficient.
// - peak ratio setting accepts only three or six.
// - below one percent of the range an input is flagged as ineffective.
// - line filter enable and cutoff select drive the front-end path.
// - frequency filter feeds period detection only at 50ms,100ms,5s,10s,20s.
// - frequency filter never touches the voltage, current or power data.
// - averaging type is selectable: exponential or moving.
// - exponential output is previous output plus (sample minus previous) over constant.
// - attenuation constant is limited to 2, 4, 8, 16, 32 or 64.
// - first update after averaging starts outputs the sample unchanged.
// - moving output is the mean of the latest window samples.
// - window length is limited to 8, 16, 32, 64, 128 or 256.
module scale_avg_top (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic [31:0]                  hrdata_out,
  output logic                         hreadyout_out,
  output logic                         hresp_out,
  input  wire logic                    upd_valid_in,
  input  wire scale_avg_pkg::ch_vec_t  raw_in,
  output logic                         upd_ready_out,
  output logic                         res_valid_out,
  output scale_avg_pkg::ch_vec_t       res_data_out,
  output logic [1:0]                   res_below_min_out,
  input  wire logic                    res_ready_in,
  output logic                         line_filter_en_out,
  output logic [1:0]                   line_cutoff_out,
  output logic                         freq_filter_period_out,
  output logic [2:0]                   peak_ratio_out
);
  import scale_avg_pkg::*;
  localparam int BW = NCH*DW + 2;

  bus_state_t   state;
  logic [31:0]  a_addr;
  logic         a_write;
  logic         take;
  logic         wr;
  logic [31:0]  rd_val;
  logic         sensor_mode;
  logic         xfmr_mode;
  logic         freq_en;
  update_rate_t rate;
  logic         rate_ok;
  logic [15:0]  sensor_ratio;
  logic [15:0]  vt_ratio;
  logic [15:0]  ct_ratio;
  logic [15:0]  power_coefficient;
  logic [15:0]  range_v;
  logic [15:0]  range_i;
  logic         next_en;
  logic         next_type;
  logic [2:0]   next_k;
  logic [3:0]   next_m;
  logic         accept;
  logic         s_valid;
  ch_vec_t      s_data;
  logic [1:0]   s_flags;
  ch_vec_t      next_scaled;
  logic [1:0]   next_flags;
  logic [15:0]  ratio_nz;
  logic [31:0]  vc_ratio;
  logic         buf_in_ready;
  logic         push;
  logic [7:0]   upd_count;
  logic [BW-1:0] buf_out;

  avg_if av ();

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // ahb-lite slave: one wait state on every transfer, so reads never race writes
  assign take = hsel_in && htrans_in[1] && hready_in && state == BUS_IDLE;
  assign wr   = state == BUS_DATA && a_write && a_addr[31:8] == 24'h000000;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state         <= BUS_IDLE;
      a_addr        <= '0;
      a_write       <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out    <= '0;
    end else begin
      case (state)
        BUS_IDLE: begin
          if (take) begin
            state         <= BUS_DATA;
            a_addr        <= haddr_in;
            a_write       <= hwrite_in;
            hreadyout_out <= 1'b0;
          end
        end
        BUS_DATA: begin
          state         <= BUS_IDLE;
          hreadyout_out <= 1'b1;
          if (!a_write) begin
            hrdata_out <= rd_val;
          end
        end
        default: begin
          state         <= BUS_IDLE;
          hreadyout_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    hresp_out <= 1'b0;
  end

  always_comb begin
    rd_val = '0;
    if (a_addr[31:8] == 24'h000000) begin
      case (a_addr[7:0])
        OFS_MODE:   rd_val = {16'h0000, rate, 3'h0, freq_en, 2'h0, line_cutoff_out, 1'b0,
                              line_filter_en_out, xfmr_mode, sensor_mode};
        OFS_AVG:    rd_val = {20'h00000, av.m_log2, 1'b0, av.k_log2, 2'h0, av.avg_type, av.enable};
        OFS_SENSOR: rd_val = {16'h0000, sensor_ratio};
        OFS_VT:     rd_val = {16'h0000, vt_ratio};
        OFS_CT:     rd_val = {16'h0000, ct_ratio};
        OFS_COEF:   rd_val = {16'h0000, power_coefficient};
        OFS_PEAK:   rd_val = {29'h00000000, peak_ratio_out};
        OFS_RANGE:  rd_val = {range_i, range_v};
        OFS_STATUS: rd_val = {16'h0000, upd_count, 3'h0, !buf_in_ready, s_flags, av.primed, s_valid};
        default:    rd_val = '0;
      endcase
    end
  end

  // mode register and ratios
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sensor_mode        <= 1'b0;
      xfmr_mode          <= 1'b0;
      line_filter_en_out <= 1'b0;
      line_cutoff_out    <= 2'h0;
      freq_en            <= 1'b0;
      rate               <= RATE_50MS;
    end else if (wr && a_addr[7:0] == OFS_MODE) begin
      sensor_mode        <= hwdata_in[MODE_SENSOR_BIT];
      xfmr_mode          <= hwdata_in[MODE_XFMR_BIT];
      line_filter_en_out <= hwdata_in[MODE_LINE_BIT];
      line_cutoff_out    <= hwdata_in[MODE_CUT_LSB +: 2];
      freq_en            <= hwdata_in[MODE_FREQ_BIT];
      if (hwdata_in[MODE_RATE_LSB +: 4] <= RATE_20S) begin
        rate <= update_rate_t'(hwdata_in[MODE_RATE_LSB +: 4]);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sensor_ratio      <= RST_RATIO;
      vt_ratio          <= RST_RATIO;
      ct_ratio          <= RST_RATIO;
      power_coefficient <= RST_COEF;
      range_v           <= RST_RANGE;
      range_i           <= RST_RANGE;
    end else if (wr) begin
      case (a_addr[7:0])
        OFS_SENSOR: sensor_ratio <= hwdata_in[15:0];
        OFS_VT:     vt_ratio <= hwdata_in[15:0];
        OFS_CT:     ct_ratio <= hwdata_in[15:0];
        OFS_COEF:   power_coefficient <= hwdata_in[15:0];
        OFS_RANGE: begin
          range_v <= hwdata_in[15:0];
          range_i <= hwdata_in[RANGE_I_LSB +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      peak_ratio_out <= PEAK_LOW;
    end else if (wr && a_addr[7:0] == OFS_PEAK &&
                 (hwdata_in[2:0] == PEAK_LOW || hwdata_in[2:0] == PEAK_HIGH) && hwdata_in[31:3] == '0) begin
      peak_ratio_out <= hwdata_in[2:0];
    end
  end

  // out-of-range constants or window lengths keep the previous setting
  always_comb begin
    next_en   = hwdata_in[AVG_EN_BIT];
    next_type = hwdata_in[AVG_TYPE_BIT];
    next_k    = av.k_log2;
    next_m    = av.m_log2;
    if (hwdata_in[AVG_K_LSB +: 3] >= K_MIN && hwdata_in[AVG_K_LSB +: 3] <= K_MAX) begin
      next_k = hwdata_in[AVG_K_LSB +: 3];
    end
    if (hwdata_in[AVG_M_LSB +: 4] >= M_MIN && hwdata_in[AVG_M_LSB +: 4] <= M_MAX) begin
      next_m = hwdata_in[AVG_M_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      av.enable   <= 1'b0;
      av.avg_type <= 1'b0;
      av.k_log2   <= K_MIN;
      av.m_log2   <= M_MIN;
      av.restart  <= 1'b0;
    end else begin
      av.restart <= 1'b0;
      if (wr && a_addr[7:0] == OFS_AVG) begin
        av.enable   <= next_en;
        av.avg_type <= next_type;
        av.k_log2   <= next_k;
        av.m_log2   <= next_m;
        av.restart  <= next_en != av.enable || next_type != av.avg_type ||
                       next_k != av.k_log2 || next_m != av.m_log2;
      end
    end
  end

  // only the period detector sees the frequency filter; the data path never does
  assign rate_ok = rate == RATE_50MS || rate == RATE_100MS || rate == RATE_5S || rate == RATE_10S ||
                   rate == RATE_20S;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      freq_filter_period_out <= 1'b0;
    end else begin
      freq_filter_period_out <= freq_en && rate_ok;
    end
  end

  // scaling, applied before the averager sees a sample
  assign ratio_nz = sensor_ratio == 16'h0000 ? 16'h0001 : sensor_ratio;
  assign vc_ratio = vt_ratio * ct_ratio;

  function automatic sample_t scale_one(sample_t x, logic dv, logic vs, logic cs, logic ps);
    sample_t d;
    d = x;
    if (sensor_mode && dv) begin
      d = d / $signed({1'b0, ratio_nz});
    end
    if (xfmr_mode && vs) begin
      d = sat(80'(d) * $signed({1'b0, vt_ratio}));
    end else if (xfmr_mode && cs) begin
      d = sat(80'(d) * $signed({1'b0, ct_ratio}));
    end else if (xfmr_mode && ps) begin
      d = sat((80'(d) * $signed({1'b0, vc_ratio}) * $signed({1'b0, power_coefficient})) >>> COEF_FRAC);
    end
    return d;
  endfunction

  for (genvar c = 0; c < NCH; c++) begin : g_scale
    assign next_scaled[c] = scale_one(raw_in[c], DIV_MASK[c], VT_MASK[c], CT_MASK[c], PWR_MASK[c]);
  end

  function automatic logic below_min(sample_t x, logic [15:0] rng);
    logic [31:0] mag;
    mag = x < 0 ? -32'(x) : 32'(x);
    return mag * MIN_LEVEL_DIV < {16'h0000, rng};
  endfunction

  assign next_flags = {below_min(raw_in[CH_I], range_i), below_min(raw_in[CH_V], range_v)};

  // single stage; ready is registered so upstream sees a flip-flop
  assign accept = upd_valid_in && upd_ready_out;
  assign push   = s_valid && buf_in_ready;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_valid       <= 1'b0;
      upd_ready_out <= 1'b1;
      s_data        <= '0;
      s_flags       <= 2'h0;
      upd_count     <= 8'h00;
    end else begin
      s_valid       <= accept || (s_valid && !push);
      upd_ready_out <= !(accept || (s_valid && !push));
      if (accept) begin
        s_data  <= next_scaled;
        s_flags <= next_flags;
      end
      if (push) begin
        upd_count <= upd_count + 8'h01;
      end
    end
  end

  assign av.in_valid = push;
  assign av.in_data  = s_data;

  avg_core u_avg (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .av     (av.core)
  );

  pair_buffer #(.W(BW)) u_buf (
    .clk_in        (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (s_valid),
    .in_ready_out  (buf_in_ready),
    .in_data_in    ({s_flags, av.out_data}),
    .out_valid_out (res_valid_out),
    .out_ready_in  (res_ready_in),
    .out_data_out  (buf_out)
  );

  assign res_data_out      = buf_out[NCH*DW-1:0];
  assign res_below_min_out = buf_out[BW-1 -: 2];

  a_peak_legal: assert property (peak_ratio_out == PEAK_LOW || peak_ratio_out == PEAK_HIGH)
    else $error("peak ratio outside three or six");
  a_atten_legal: assert property (av.k_log2 >= K_MIN && av.k_log2 <= K_MAX)
    else $error("attenuation constant out of range");
  a_window_legal: assert property (av.m_log2 >= M_MIN && av.m_log2 <= M_MAX)
    else $error("window length out of range");
  a_restart_on: assert property (wr && a_addr[7:0] == OFS_AVG && hwdata_in[AVG_TYPE_BIT] != av.avg_type |=> av.restart)
    else $error("type change did not restart averaging");
  a_stage_stall: assert property (s_valid && !buf_in_ready |=> s_valid && $stable(s_data))
    else $error("scaled sample lost under stall");
  a_ext_divide: assert property (accept && sensor_mode && !xfmr_mode && sensor_ratio == 16'h0002 |=>
    s_data[CH_P] == $past(raw_in[CH_P]) / 24'sd2)
    else $error("sensor division wrong");
  a_vt_scale: assert property (accept && xfmr_mode && !sensor_mode && vt_ratio == 16'h0002 &&
    raw_in[CH_UPK] < 24'sd1000 && raw_in[CH_UPK] > -24'sd1000 |=>
    s_data[CH_UPK] == $past(raw_in[CH_UPK]) * 24'sd2)
    else $error("voltage transformer scaling wrong");
  a_ct_scale: assert property (accept && xfmr_mode && !sensor_mode && ct_ratio == 16'h0003 &&
    raw_in[CH_I] < 24'sd1000 && raw_in[CH_I] > -24'sd1000 |=>
    s_data[CH_I] == $past(raw_in[CH_I]) * 24'sd3)
    else $error("current transformer scaling wrong");
  a_freq_gate: assert property (rate == RATE_250MS ##1 rate == RATE_250MS |-> !freq_filter_period_out)
    else $error("frequency filter routed at an excluded rate");
  a_out_hold: assert property (res_valid_out && !res_ready_in |=> res_valid_out && $stable(res_data_out))
    else $error("result dropped under back-pressure");
  a_bus_wait: assert property (take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("bus wait state wrong");

  c_moving: cover property (push && av.enable && av.avg_type);
  c_expo: cover property (push && av.enable && !av.avg_type);
  c_stall: cover property (s_valid && !buf_in_ready);
  c_restart: cover property (av.restart ##[1:20] push);
endmodule

// ---- tb/raw_source.sv ----
/* upstream engine model: offers one raw vector per update.
   assumes the block takes it on an edge with ready high. */
`timescale 1ns/10ps
module raw_source (
  input  wire logic             clk_in,
  input  wire logic             ready_in,
  output logic                  valid_out,
  output scale_avg_pkg::ch_vec_t raw_out
);
  import scale_avg_pkg::*;
  initial begin
    valid_out = 1'b0;
    raw_out   = '0;
  end
  task automatic push(input ch_vec_t v);
    valid_out <= 1'b1;
    raw_out   <= v;
    do @(posedge clk_in); while (ready_in !== 1'b1);
    valid_out <= 1'b0;
    // released lines show the inverse, never the stale vector
    raw_out   <= ~v;
    // spacing keeps one strobe per update
    @(posedge clk_in);
  endtask
endmodule

// ---- tb/tb_top.sv ----
/* directed bench: ahb register tasks plus raw pushes, results compared.
   assumes a 4 ns clock; ahb waits follow hready, never a fixed count. */
`timescale 1ns/10ps
module tb_top;
  import scale_avg_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, hsel = 0, hwrite = 0, rdy = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic hreadyout, hresp, upd_valid, upd_ready, res_valid, lf_en, fp;
  logic [1:0] cut, below;
  logic [2:0] peak;
  ch_vec_t raw, res;
  int err_total = 0, checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  scale_avg_top uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .upd_valid_in(upd_valid),
    .raw_in(raw), .upd_ready_out(upd_ready), .res_valid_out(res_valid), .res_data_out(res),
    .res_below_min_out(below), .res_ready_in(rdy), .line_filter_en_out(lf_en), .line_cutoff_out(cut),
    .freq_filter_period_out(fp), .peak_ratio_out(peak));
  raw_source src (.clk_in(clk_sys_in), .ready_in(upd_ready), .valid_out(upd_valid), .raw_out(raw));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic ch_vec_t vec(input int v, input int i, input int p);
    vec = '0;
    vec[0] = v[23:0];
    vec[1] = i[23:0];
    vec[2] = p[23:0];
  endfunction
  // a result is compared on the edge at which the receiver takes it
  task automatic get(input int ev, input int ei, input int ep, input logic [1:0] eb = 2'b00);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (res_valid !== 1'b1 && n < 50);
    cmp("res_valid", 1, res_valid);
    cmp("res_v", ev, res[0]);
    cmp("res_i", ei, res[1]);
    cmp("res_p", ep, res[2]);
    cmp("below_min", eb, below);
  endtask
  task automatic done(input string n);
    $display("test %s ended", n);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    cmp("peak_rst", 3, peak);
    ahb(1, OFS_PEAK, 6);
    cmp("peak6", 6, peak);
    ahb(1, OFS_PEAK, 5);
    cmp("peak5", 6, peak);
    ahb(0, 8'h40, 0);
    cmp("unmapped", 0, rd);
    cmp("hresp", 0, hresp);
    done("config");
    ahb(1, OFS_MODE, 32'h134);
    repeat (3) @(posedge clk_sys_in);
    cmp("line_en", 1, lf_en);
    cmp("cutoff", 3, cut);
    cmp("freq50", 1, fp);
    src.push(vec(10, 20, 30));
    get(10, 20, 30);
    ahb(1, OFS_MODE, 32'h2104);
    repeat (3) @(posedge clk_sys_in);
    cmp("freq250", 0, fp);
    done("filters");
    ahb(1, OFS_SENSOR, 2);
    ahb(1, OFS_MODE, 1);
    src.push(vec(40, 400, 800));
    get(40, 200, 400);
    ahb(1, OFS_VT, 2);
    ahb(1, OFS_CT, 3);
    ahb(1, OFS_MODE, 2);
    src.push(vec(10, 10, 10));
    get(20, 30, 60);
    ahb(1, OFS_MODE, 0);
    done("scaling");
    ahb(1, OFS_AVG, 32'h11);
    src.push(vec(100, 100, 100));
    get(100, 100, 100);
    src.push(vec(200, 200, 200));
    get(150, 150, 150);
    ahb(1, OFS_AVG, 32'h61);
    src.push(vec(640, 640, 640));
    get(640, 640, 640);
    src.push(vec(0, 0, 0));
    get(630, 630, 630, 2'b11);
    ahb(1, OFS_AVG, 32'h303);
    ahb(0, OFS_AVG, 0);
    cmp("avg_reg", 32'h363, rd);
    src.push(vec(80, 80, 80));
    get(80, 80, 80);
    src.push(vec(160, 160, 160));
    get(90, 90, 90);
    done("averaging");
    ahb(1, OFS_AVG, 0);
    rdy <= 1'b0;
    src.push(vec(5, 5, 5));
    src.push(vec(6, 6, 6));
    rdy <= 1'b1;
    get(5, 5, 5);
    get(6, 6, 6);
    done("stall");
    print_verdict();
  end
endmodule
